// [common/tisk_defs.vh]
// tisk_defs.vh: register offsets, field positions, codes and timing counts
// assumes: included by bare name from the design files
`ifndef TISK_DEFS_VH
`define TISK_DEFS_VH
// register byte addresses, one word each
`define TISK_REG_TILT     8'h00
`define TISK_REG_SETPT    8'h04
`define TISK_REG_KEYLOCK  8'h08
`define TISK_REG_PORT2    8'h0C
`define TISK_REG_STATUS   8'h10
`define TISK_REG_EVENT    8'h14
// tilt option codes
`define TISK_TILT_OFF     7'd0
`define TISK_TILT_MAXDLY  7'd90
`define TISK_TILT_TARE    7'd91
`define TISK_TILT_PRINT   7'd92
`define TISK_TILT_LEVEL   7'd93
`define TISK_TILT_TARESP  7'd94
`define TISK_TILT_SCALE   7'd95
`define TISK_TILT_ZERO    7'd96
// setpoint register fields
`define TISK_SP1_NOMOT    0
`define TISK_SP1_ERR      1
`define TISK_SP2_ZERO     2
`define TISK_SP2_NET      3
`define TISK_SP_GROSS     5
`define TISK_SP_NCLOSED   6
// second port: function in [6:0], rate in [14:8], frame in [20:16]
`define TISK_FN_OFF       7'd0
`define TISK_FN_CONT      7'd1
`define TISK_FN_HOSTDATA  7'd2
`define TISK_FN_PRINTER   7'd3
`define TISK_FN_CONTTARE  7'd6
`define TISK_FN_DUAL      7'd11
`define TISK_FN_MSLO      7'd65
`define TISK_FN_MSHI      7'd89
`define TISK_BAUD_2400    7'd24
`define TISK_BAUD_9600    7'd96
`define TISK_BAUD_19200   7'd19
`define TISK_BAUD_38400   7'd38
`define TISK_BAUD_57600   7'd57
`define TISK_FRM_7E       5'd17
`define TISK_FRM_8N       5'd8
`define TISK_FRM_8E       5'd18
// role encodings shown in status
`define TISK_ROLE_OFF     3'h0
`define TISK_ROLE_CONT    3'h1
`define TISK_ROLE_HOST    3'h2
`define TISK_ROLE_PRN     3'h3
`define TISK_ROLE_CTARE   3'h4
`define TISK_ROLE_DUAL    3'h5
`define TISK_ROLE_MS      3'h6
`define TISK_ROLE_BAD     3'h7
// timing
`define TISK_CLK_HZ       100000000
`define TISK_TICK_MS      100
`define TISK_TICK_CYC     ((`TISK_CLK_HZ / 1000) * `TISK_TICK_MS)
`endif

// [design/tisk_sync.v]
// tisk_sync.v: three-stage input synchroniser with agreement filter
// assumes: din is asynchronous to clk; output moves when stages 2 and 3 agree
`timescale 1ns/100ps
module tisk_sync (
  // clock and reset
  input  wire ref_clk,
  input  wire rstn,
  // data
  input  wire din,
  output reg  dout
);
  reg stage1;
  reg stage2;
  reg stage3;

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      dout   <= 1'b0;
    end else begin
      stage1 <= din;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3) begin
        dout <= stage3;
      end
    end
  end
endmodule // tisk_sync

// [design/tisk_tick.v]
// tisk_tick.v: free-running divider giving a one-cycle pulse per period
// assumes: single clock, PERIOD at least 2
`timescale 1ns/100ps
module tisk_tick #(
  parameter PERIOD = 10000000
) (
  // clock and reset
  input  wire ref_clk,
  input  wire rstn,
  // output
  output reg  tick
);
  reg [31:0] count;

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      count <= 32'h0000_0000;
      tick  <= 1'b0;
    end else if (count == PERIOD - 1) begin
      count <= 32'h0000_0000;
      tick  <= 1'b1;
    end else begin
      count <= count + 32'h0000_0001;
      tick  <= 1'b0;
    end
  end
endmodule // tisk_tick

// [design/tisk_ctrl.v]
// tisk_ctrl.v: tilt input, setpoint outputs, key locks, second port setup
// assumes: classic wishbone slave, ack one cycle after request, one clock
`timescale 1ns/100ps
`include "tisk_defs.vh"
module tisk_ctrl #(
  parameter TICK_CYC = `TISK_TICK_CYC
) (
  // clock and reset
  input  wire        ref_clk,
  input  wire        rstn,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // tilt contact and scale status
  input  wire        tiltContact,
  input  wire        tareDone,
  input  wire        tareOk,
  input  wire        spMatch1,
  input  wire        spMatch2,
  input  wire        noMotion,
  input  wire        scaleError,
  input  wire        atZero,
  input  wire        netActive,
  // front keys, raw presses
  input  wire [6:0]  keyPress,
  // requests and state to the weighing core
  output reg         displayLock,
  output reg         tareReq,
  output reg         printReq,
  output reg         zeroReq,
  output reg         scaleSel,
  output reg         useGross,
  output reg  [6:0]  keyAccept,
  // setpoint relays
  output reg         spOut1,
  output reg         spOut2,
  // second port setup
  output reg  [2:0]  port2Role,
  output reg  [6:0]  port2Addr,
  output reg  [2:0]  port2Baud,
  output reg         port2Bits8,
  output reg         port2Parity,
  output reg         port2CfgBad
);
  // software registers
  reg [6:0]  tiltCode;
  reg [6:0]  spCfg;
  reg [6:0]  keyLock;
  reg [6:0]  fnCode;
  reg [6:0]  baudCode;
  reg [4:0]  frameCode;
  reg [3:0]  evSticky;

  // tilt state
  reg        contactPrev;
  reg        lockTarget;
  reg [6:0]  dlyCount;
  reg        tarePending;
  reg        spArmed;
  reg        spEnable;
  reg        next_spEnable;

  // bus, decode nets
  wire       contact;
  wire       tick;
  wire       riseEdge;
  wire       wbReq;
  wire       wbWr;
  wire [31:0] wmask;
  wire [31:0] wdata;
  reg  [31:0] rdata;
  reg        sp1Act;
  reg        sp2Act;
  reg        delayMode;

  // three stages plus agreement filter: one-cycle chatter never reaches the edge logic
  tisk_sync uSync (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .din     (tiltContact),
    .dout    (contact)
  );

  // free-running phase: a delay lasts n-1 to n tenths, plus synchroniser latency
  tisk_tick #(
    .PERIOD (TICK_CYC)
  ) uTick (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .tick    (tick)
  );

  assign riseEdge = contact & ~contactPrev;
  // ack in the request term gives one ack per strobe on a held request
  assign wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wbWr  = wbReq & wb_we_i;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wdata = wb_dat_i & wmask;

  always @* begin
    delayMode = (tiltCode != `TISK_TILT_OFF) && (tiltCode <= `TISK_TILT_MAXDLY);
  end

  // bus slave: ack one cycle after request, unmapped reads zero
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h0000_0000;
      tiltCode  <= 7'h00;
      spCfg     <= 7'h00;
      keyLock   <= 7'h00;
      fnCode    <= 7'h00;
      baudCode  <= `TISK_BAUD_9600;
      frameCode <= `TISK_FRM_8N;
    end else begin
      wb_ack_o <= wbReq;
      if (wbReq && !wb_we_i) begin
        wb_dat_o <= rdata;
      end
      if (wbWr) begin
        case (wb_adr_i)
          `TISK_REG_TILT: begin
            tiltCode <= (tiltCode & ~wmask[6:0]) | wdata[6:0];
          end
          `TISK_REG_SETPT: begin
            spCfg <= (spCfg & ~wmask[6:0]) | wdata[6:0];
          end
          `TISK_REG_KEYLOCK: begin
            keyLock <= (keyLock & ~wmask[6:0]) | wdata[6:0];
          end
          `TISK_REG_PORT2: begin
            fnCode    <= (fnCode & ~wmask[6:0]) | wdata[6:0];
            baudCode  <= (baudCode & ~wmask[14:8]) | wdata[14:8];
            frameCode <= (frameCode & ~wmask[20:16]) | wdata[20:16];
          end
          default: begin
          end
        endcase
      end
    end
  end

  always @* begin
    case (wb_adr_i)
      `TISK_REG_TILT:    rdata = {25'h0, tiltCode};
      `TISK_REG_SETPT:   rdata = {25'h0, spCfg};
      `TISK_REG_KEYLOCK: rdata = {25'h0, keyLock};
      `TISK_REG_PORT2:   rdata = {11'h0, frameCode, 1'b0, baudCode, 1'b0, fnCode};
      `TISK_REG_STATUS:  rdata = {16'h0, 1'b0, port2CfgBad, port2Role, port2Baud,
                                  spOut2, spOut1, spEnable, scaleSel, displayLock,
                                  lockTarget, contact, 1'b0};
      `TISK_REG_EVENT:   rdata = {28'h0, evSticky};
      default:           rdata = 32'h0000_0000;
    endcase
  end

  // tilt delay: restart on change, count ticks until target reached
  // codes above 90 keep the lock released
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      contactPrev <= 1'b0;
      lockTarget  <= 1'b0;
      dlyCount    <= 7'h00;
      displayLock <= 1'b0;
    end else begin
      contactPrev <= contact;
      if (!delayMode) begin
        displayLock <= 1'b0;
        dlyCount    <= 7'h00;
        lockTarget  <= contact;
      end else if (contact != lockTarget) begin
        lockTarget <= contact;
        dlyCount   <= 7'h00;
      end else if (displayLock != lockTarget && tick) begin
        if (dlyCount + 7'h01 >= tiltCode) begin
          displayLock <= lockTarget;
          dlyCount    <= 7'h00;
        end else begin
          dlyCount <= dlyCount + 7'h01;
        end
      end
    end
  end

  // special options
  // codes 97 up behave like 0: setpoints enabled, no lock, no requests
  always @* begin
    case (tiltCode)
      `TISK_TILT_LEVEL:  next_spEnable = contact;
      `TISK_TILT_TARESP: next_spEnable = contact & spArmed;
      default:           next_spEnable = 1'b1;
    endcase
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tareReq     <= 1'b0;
      printReq    <= 1'b0;
      zeroReq     <= 1'b0;
      scaleSel    <= 1'b0;
      tarePending <= 1'b0;
      spArmed     <= 1'b0;
      spEnable    <= 1'b1;
      evSticky    <= 4'h0;
    end else begin
      tareReq  <= riseEdge &&
                  (tiltCode == `TISK_TILT_TARE || tiltCode == `TISK_TILT_TARESP);
      printReq <= riseEdge && (tiltCode == `TISK_TILT_PRINT);
      zeroReq  <= riseEdge && (tiltCode == `TISK_TILT_ZERO);
      scaleSel <= (tiltCode == `TISK_TILT_SCALE) ? contact : 1'b0;
      spEnable <= next_spEnable;
      if (tiltCode != `TISK_TILT_TARESP || !contact) begin
        spArmed     <= 1'b0;
        tarePending <= 1'b0;
      end else if (riseEdge) begin
        tarePending <= 1'b1;
        spArmed     <= 1'b0;
      end else if (tarePending && tareDone) begin
        tarePending <= 1'b0;
        spArmed     <= tareOk;
      end
      // sticky record of contact rising edges and issued requests; write-one clears, set wins
      evSticky <= (evSticky & ~((wbWr && wb_adr_i == `TISK_REG_EVENT) ? wdata[3:0] : 4'h0))
                  | {zeroReq, printReq, tareReq, riseEdge};
    end
  end

  // setpoint outputs
  always @* begin
    case (spCfg[`TISK_SP1_ERR:`TISK_SP1_NOMOT])
      2'b01:   sp1Act = noMotion;
      2'b10:   sp1Act = scaleError;
      default: sp1Act = spMatch1;
    endcase
    case (spCfg[`TISK_SP2_NET:`TISK_SP2_ZERO])
      2'b01:   sp2Act = atZero;
      2'b10:   sp2Act = netActive;
      default: sp2Act = spMatch2;
    endcase
  end

  // relays, key gate registered: no decode glitch ever reaches a coil
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      spOut1    <= 1'b0;
      spOut2    <= 1'b0;
      useGross  <= 1'b0;
      keyAccept <= 7'h00;
    end else begin
      useGross  <= spCfg[`TISK_SP_GROSS];
      spOut1    <= (spEnable & sp1Act) ^ spCfg[`TISK_SP_NCLOSED];
      spOut2    <= (spEnable & sp2Act) ^ spCfg[`TISK_SP_NCLOSED];
      keyAccept <= keyPress & ~keyLock;
    end
  end

  // second port decode
  // unknown codes flagged; frame falls back to 8N so the port stays usable
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      port2Role   <= `TISK_ROLE_OFF;
      port2Addr   <= 7'h00;
      port2Baud   <= 3'h1;
      port2Bits8  <= 1'b1;
      port2Parity <= 1'b0;
      port2CfgBad <= 1'b0;
    end else begin
      port2Addr <= 7'h00;
      case (fnCode)
        `TISK_FN_OFF:      port2Role <= `TISK_ROLE_OFF;
        `TISK_FN_CONT:     port2Role <= `TISK_ROLE_CONT;
        `TISK_FN_HOSTDATA: port2Role <= `TISK_ROLE_HOST;
        `TISK_FN_PRINTER:  port2Role <= `TISK_ROLE_PRN;
        `TISK_FN_CONTTARE: port2Role <= `TISK_ROLE_CTARE;
        `TISK_FN_DUAL:     port2Role <= `TISK_ROLE_DUAL;
        default: begin
          if (fnCode >= `TISK_FN_MSLO && fnCode <= `TISK_FN_MSHI) begin
            port2Role <= `TISK_ROLE_MS;
            port2Addr <= fnCode;
          end else begin
            port2Role <= `TISK_ROLE_BAD;
          end
        end
      endcase
      case (baudCode)
        `TISK_BAUD_2400:  port2Baud <= 3'h0;
        `TISK_BAUD_9600:  port2Baud <= 3'h1;
        `TISK_BAUD_19200: port2Baud <= 3'h2;
        `TISK_BAUD_38400: port2Baud <= 3'h3;
        `TISK_BAUD_57600: port2Baud <= 3'h4;
        default:          port2Baud <= 3'h7;
      endcase
      case (frameCode)
        `TISK_FRM_7E: begin
          port2Bits8  <= 1'b0;
          port2Parity <= 1'b1;
        end
        `TISK_FRM_8N: begin
          port2Bits8  <= 1'b1;
          port2Parity <= 1'b0;
        end
        `TISK_FRM_8E: begin
          port2Bits8  <= 1'b1;
          port2Parity <= 1'b1;
        end
        default: begin
          port2Bits8  <= 1'b1;
          port2Parity <= 1'b0;
        end
      endcase
      port2CfgBad <= (baudCode != `TISK_BAUD_2400 && baudCode != `TISK_BAUD_9600 &&
                      baudCode != `TISK_BAUD_19200 && baudCode != `TISK_BAUD_38400 &&
                      baudCode != `TISK_BAUD_57600) ||
                     (frameCode != `TISK_FRM_7E && frameCode != `TISK_FRM_8N &&
                      frameCode != `TISK_FRM_8E);
    end
  end
endmodule // tisk_ctrl

// [verif/tisk_asserts.sv]
// tisk_asserts.sv: port checker for tisk_ctrl
// assumes: bound to tisk_ctrl, one clock, async low reset
`timescale 1ns/100ps
`include "tisk_defs.vh"
module tisk_asserts #(
  parameter TICK_CYC = 10
) (
  // clock and reset
  input wire       ref_clk,
  input wire       rstn,
  // bus
  input wire       wb_cyc_i,
  input wire       wb_stb_i,
  input wire       wb_ack_o,
  // keys and requests
  input wire [6:0] keyPress,
  input wire [6:0] keyAccept,
  input wire       tareReq,
  input wire       printReq,
  input wire       zeroReq,
  // second port
  input wire [2:0] port2Role,
  input wire [6:0] port2Addr,
  input wire [2:0] port2Baud,
  input wire       port2Bits8,
  input wire       port2Parity,
  input wire       port2CfgBad
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  sequence reqTaken;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ackPulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_next_cycle: assert property (reqTaken |=> ackPulse)
    else $error("ack not one cycle after request");
  a_ack_has_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i & wb_stb_i))
    else $error("ack without request");
  a_key_lock_gate: assert property ((keyAccept & ~$past(keyPress)) == 7'h00)
    else $error("key accepted without press");
  a_tare_single: assert property (tareReq |=> !tareReq)
    else $error("tare request longer than one cycle");
  a_print_single: assert property (printReq |=> !printReq)
    else $error("print request longer than one cycle");
  a_zero_single: assert property (zeroReq |=> !zeroReq)
    else $error("zero request longer than one cycle");
  a_ms_addr_range: assert property ((port2Role == `TISK_ROLE_MS) ==
    (port2Addr inside {[7'h41:7'h59]})) else $error("address and role disagree");
  a_baud_legal: assert property (port2Baud <= 3'h4 || port2Baud == 3'h7)
    else $error("rate encoding out of range");
  a_frame_legal: assert property (!port2CfgBad |-> (port2Bits8 || port2Parity))
    else $error("seven bits without parity");
endmodule // tisk_asserts

bind tisk_ctrl tisk_asserts #(.TICK_CYC(TICK_CYC)) u_chk (.ref_clk, .rstn, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .keyPress, .keyAccept, .tareReq, .printReq, .zeroReq,
  .port2Role, .port2Addr, .port2Baud, .port2Bits8, .port2Parity, .port2CfgBad);

// [verif/tisk_contact_model.sv]
// tisk_contact_model.sv: tilt contact with chatter, relay coil view
// assumes: closeCmd from the bench, changed just after a clock edge
`timescale 1ns/100ps
module tisk_contact_model (
  // clock
  input  wire       ref_clk,
  // bench side
  input  wire       closeCmd,
  output wire [1:0] relayOn,
  // block side
  output reg        tiltContact,
  input  wire       spOut1,
  input  wire       spOut2
);
  reg       last = 1'b0;
  reg [1:0] age  = 2'h3;
  initial tiltContact = 1'b0;
  // one reversal after each change, as a real contact chatters
  always @(posedge ref_clk) begin
    last <= closeCmd;
    age <= (closeCmd != last) ? 2'h0 : (age == 2'h3) ? age : age + 2'h1;
    tiltContact <= (age == 2'h0 && closeCmd == last) ? ~closeCmd : closeCmd;
  end
  // coil drive seen as is; polarity already folded in by the block
  assign relayOn = {spOut2, spOut1};
endmodule // tisk_contact_model

// [verif/tb_tilt_input_setpoint_keylock_ctrl.sv]
// tb_tilt_input_setpoint_keylock_ctrl.sv: self-checking bench for tisk_ctrl
// assumes: contact model on the tilt pin, tick shortened to 10 cycles
`timescale 1ns/100ps
module tb_tilt_input_setpoint_keylock_ctrl;
  reg         ref_clk, rstn, closeCmd, wb_cyc_i, wb_stb_i, wb_we_i;
  reg  [7:0]  wb_adr_i;
  reg  [3:0]  wb_sel_i;
  reg  [31:0] wb_dat_i, rd;
  reg         tareDone, tareOk, spMatch1, spMatch2, noMotion, scaleError, atZero, netActive;
  reg  [6:0]  keyPress;
  reg  [11:0] reqCnt;
  wire [31:0] wb_dat_o;
  wire        wb_ack_o, tiltContact, displayLock, tareReq, printReq, zeroReq, scaleSel;
  wire        useGross, spOut1, spOut2, port2Bits8, port2Parity, port2CfgBad;
  wire [6:0]  keyAccept, port2Addr;
  wire [2:0]  port2Role, port2Baud;
  wire [1:0]  relayOn;
  wire [15:0] p2St = {port2CfgBad, port2Role, port2Baud, port2Bits8, port2Parity, port2Addr};
  int         errorCnt, checks, cycles;
  reg  [6:0]  rT [0:4] = '{7'h18, 7'h60, 7'h13, 7'h26, 7'h39};
  reg  [4:0]  fT [0:2] = '{5'h11, 5'h08, 5'h12};
  reg  [1:0]  bT [0:2] = '{2'h1, 2'h2, 2'h3};
  reg  [6:0]  nT [0:7] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h06, 7'h0B, 7'h41, 7'h59};
  reg  [6:0]  eT [0:2] = '{7'h5B, 7'h5C, 7'h60};
  reg  [11:0] eX [0:2] = '{12'h100, 12'h010, 12'h001};
  // setpoint cfg, six status inputs, expected {sp2, sp1} coils
  reg  [15:0] sT [0:10] = '{16'h0081, 16'h0042, 16'h0180, 16'h0121, 16'h0211, 16'h040A,
                            16'h0440, 16'h0806, 16'h4082, 16'h2081, 16'h0381};

  tisk_ctrl #(.TICK_CYC(10)) u_dut (.ref_clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .tiltContact, .tareDone,
    .tareOk, .spMatch1, .spMatch2, .noMotion, .scaleError, .atZero, .netActive,
    .keyPress, .displayLock, .tareReq, .printReq, .zeroReq, .scaleSel, .useGross,
    .keyAccept, .spOut1, .spOut2, .port2Role, .port2Addr, .port2Baud, .port2Bits8,
    .port2Parity, .port2CfgBad);
  tisk_contact_model u_contact (.ref_clk, .closeCmd, .relayOn, .tiltContact, .spOut1,
    .spOut2);

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // request pulses counted per kind, plus a hang guard
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    reqCnt <= reqCnt + {3'h0, tareReq, 3'h0, printReq, 3'h0, zeroReq};
    if (cycles == 5000) begin
      errorCnt = errorCnt + 1;
      tally_and_finish;
    end
  end

  task tally_and_finish;
    if (errorCnt == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input [31:0] g, input [31:0] e);
    checks = checks + 1;
    if (g !== e) begin
      errorCnt = errorCnt + 1;
      $display("CHECK FAILED %0t got %0h exp %0h", $time, g, e);
    end
  endtask
  task w(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task sw(input v, input int n);
    closeCmd <= v;
    w(n);
  endtask
  // one classic cycle; no fixed latency assumed
  task wb(input [7:0] a, input [31:0] d, input we);
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'hF;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task pc(input [6:0] f, input [6:0] r, input [4:0] m, input [15:0] e);
    wb(8'h0C, {11'h000, m, 1'b0, r, 1'b0, f}, 1'b1);
    w(3);
    chk(p2St, e);
  endtask

  task t_regs;
    chk(p2St, 16'h0300);
    wb(8'h0C, 32'h0, 1'b0);
    chk(rd, 32'h00086000);
    wb(8'h20, 32'hFFFFFFFF, 1'b1);
    wb(8'h20, 32'h0, 1'b0);
    chk(rd, 32'h0);
  endtask
  task t_port;
    int i;
    for (i = 0; i < 5; i++) pc(7'h00, rT[i], 5'h08, {4'h0, i[2:0], 9'h100});
    for (i = 0; i < 3; i++) pc(7'h00, 7'h60, fT[i], {7'h01, bT[i], 7'h00});
    for (i = 0; i < 8; i++) pc(nT[i], 7'h60, 5'h08,
      {1'b0, (i < 6) ? i[2:0] : 3'h6, 5'h06, (i > 5) ? nT[i] : 7'h00});
    pc(7'h40, 7'h60, 5'h08, 16'h7300);
    pc(7'h00, 7'h0C, 5'h08, 16'h8F00);
  endtask
  task t_keys;
    wb(8'h08, 32'h00000055, 1'b1);
    keyPress <= 7'h7F;
    w(3);
    chk(keyAccept, 7'h2A);
    keyPress <= 7'h00;
  endtask
  task t_sp;
    int i;
    wb(8'h00, 32'h5B, 1'b1);
    for (i = 0; i < 11; i++) begin
      wb(8'h04, {24'h0, sT[i][15:8]}, 1'b1);
      {spMatch1, spMatch2, noMotion, scaleError, atZero, netActive} <= sT[i][7:2];
      w(4);
      chk(relayOn, sT[i][1:0]);
      chk(useGross, sT[i][13]);
    end
    wb(8'h04, 32'h0, 1'b1);
  endtask
  task t_edges;
    int i;
    reg [11:0] b;
    {spMatch1, spMatch2} <= 2'h3;
    for (i = 0; i < 3; i++) begin
      wb(8'h00, {25'h0, eT[i]}, 1'b1);
      b = reqCnt;
      sw(1'b1, 12);
      sw(1'b0, 12);
      chk(reqCnt - b, eX[i]);
      if (i < 2) chk(relayOn, 2'h3);
    end
    wb(8'h14, 32'h0, 1'b0);
    chk(rd, 32'h0000000F);
    wb(8'h14, 32'h0000000F, 1'b1);
    wb(8'h14, 32'h0, 1'b0);
    chk(rd, 32'h0);
  endtask
  task t_level;
    wb(8'h00, 32'h5D, 1'b1);
    w(8);
    chk(relayOn, 2'h0);
    sw(1'b1, 10);
    chk(relayOn, 2'h3);
    sw(1'b0, 10);
    chk(relayOn, 2'h0);
    wb(8'h00, 32'h5F, 1'b1);
    sw(1'b1, 10);
    chk(scaleSel, 1'b1);
    sw(1'b0, 10);
    chk(scaleSel, 1'b0);
  endtask
  task t_tsp;
    wb(8'h00, 32'h5E, 1'b1);
    sw(1'b1, 10);
    chk(relayOn, 2'h0);
    {tareDone, tareOk} <= 2'h2;
    w(1);
    tareDone <= 1'b0;
    w(4);
    chk(relayOn, 2'h0);
    // a failed tare disarms; arming again needs a fresh rising edge
    sw(1'b0, 10);
    sw(1'b1, 10);
    {tareDone, tareOk} <= 2'h3;
    w(1);
    tareDone <= 1'b0;
    w(4);
    chk(relayOn, 2'h3);
    sw(1'b0, 10);
    chk(relayOn, 2'h0);
  endtask
  // delay 3 tenths, tick every 10 cycles: lock 29 to 38 cycles after the command
  task t_delay;
    wb(8'h00, 32'h03, 1'b1);
    sw(1'b1, 15);
    chk(displayLock, 1'b0);
    w(30);
    chk(displayLock, 1'b1);
    sw(1'b0, 10);
    sw(1'b1, 30);
    chk(displayLock, 1'b1);
    sw(1'b0, 15);
    chk(displayLock, 1'b1);
    w(30);
    chk(displayLock, 1'b0);
    wb(8'h00, 32'h0, 1'b1);
    sw(1'b1, 60);
    chk(displayLock, 1'b0);
  endtask

  initial begin
    rstn = 1'b0;
    closeCmd = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = 43'h0;
    wb_sel_i = 4'hF;
    {tareDone, tareOk, spMatch1, spMatch2, noMotion, scaleError, atZero, netActive} = 8'h00;
    keyPress = 7'h00;
    reqCnt = 12'h000;
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    t_regs;
    t_port;
    t_keys;
    t_sp;
    t_edges;
    t_level;
    t_tsp;
    t_delay;
    tally_and_finish;
  end
endmodule // tb_tilt_input_setpoint_keylock_ctrl
